// ### common/mpac_ctl_if.sv
interface mpac_ctl_if;
  logic page_close_policy;
  logic page_miss;
  logic row_change;
  logic pages_open;
  logic refresh_start;
  logic [1:0] precharge;
  modport regs (output page_close_policy, input precharge);
  modport pre (input page_close_policy, page_miss, row_change, pages_open,
    refresh_start, output precharge);
endinterface

// ### common/mpac_pkg.sv
package mpac_pkg;
  localparam logic [7:0] MEM_CFG_OFFSET = 8'h50;
  localparam logic [7:0] APCTL_OFFSET = 8'h51;
  localparam logic [7:0] SMM_RAM_OFFSET = 8'h70;
  localparam int POLICY_BIT = 3;
  localparam int FREQ_BIT = 2;
  localparam int LOCK_BIT = 2;
  localparam int GATE_BIT = 1;
  localparam int SELECT_BIT = 0;
  localparam logic [7:0] APCTL_RESET = 8'h00;
  localparam logic [7:0] APCTL_MASK = 8'h07;
  localparam logic [7:0] MEM_CFG_MASK = 8'h0C;
  localparam logic [7:0] SMM_RAM_RESET = 8'h00;
  localparam logic [1:0] GFX_MEM_OFF = 2'h0;
  localparam int GFX_MEM_MSB = 7;
  localparam int GFX_MEM_LSB = 6;
  localparam logic [1:0] DEV_HOST = 2'h0;
  localparam logic [1:0] DEV_AGP = 2'h1;
  localparam logic [1:0] DEV_GFX = 2'h2;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ALL_ZEROS = 8'h00;
  typedef enum logic [1:0] {PRE_NONE, PRE_BANK, PRE_ALL} mpac_pre_t;
endpackage

// ### rtl/mpac_precharge.sv
module mpac_precharge (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // policy and events
  mpac_ctl_if.pre ctl
);
  mpac_pkg::mpac_pre_t cmd;
  mpac_pkg::mpac_pre_t next_cmd;

  always_comb begin
    next_cmd = mpac_pkg::PRE_NONE;
    if (ctl.refresh_start || (ctl.row_change && ctl.pages_open)) begin
      next_cmd = mpac_pkg::PRE_ALL;
    end else if (ctl.page_miss) begin
      if (ctl.page_close_policy) begin
        next_cmd = mpac_pkg::PRE_ALL;
      end else begin
        next_cmd = mpac_pkg::PRE_BANK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd <= mpac_pkg::PRE_NONE;
    end else begin
      cmd <= next_cmd;
    end
  end

  assign ctl.precharge = cmd;

  property p_open_miss;
    @(posedge ref_clk) disable iff (rst)
    (ctl.page_miss && !ctl.page_close_policy && !ctl.refresh_start
      && !(ctl.row_change && ctl.pages_open))
      |=> ctl.precharge == mpac_pkg::PRE_BANK;
  endproperty
  a_open_miss: assert property (p_open_miss)
    else $error("open policy miss did not precharge one bank");

  property p_closed_miss;
    @(posedge ref_clk) disable iff (rst)
    (ctl.page_miss && ctl.page_close_policy)
      |=> ctl.precharge == mpac_pkg::PRE_ALL;
  endproperty
  a_closed_miss: assert property (p_closed_miss)
    else $error("closed policy miss did not precharge all");

  property p_refresh_row;
    @(posedge ref_clk) disable iff (rst)
    (ctl.refresh_start || (ctl.row_change && ctl.pages_open))
      |=> ctl.precharge == mpac_pkg::PRE_ALL;
  endproperty
  a_refresh_row: assert property (p_refresh_row)
    else $error("refresh or row change did not precharge all");
endmodule // mpac_precharge

// ### rtl/mpac_regs.sv
module mpac_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // strap
  input wire logic sysmem_freq_strap,
  // configuration cycle port
  input wire logic [1:0] cfg_dev,
  input wire logic [7:0] cfg_offset,
  input wire logic cfg_agp_reg,
  input wire logic cfg_read,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_claim,
  // memory controller events
  input wire logic page_miss,
  input wire logic row_change,
  input wire logic pages_open,
  input wire logic refresh_start,
  output logic [1:0] precharge,
  // frequency and graphics path status
  output logic sysmem_freq_select,
  output logic agp_enable,
  output logic gfx_enable,
  // aperture access check
  input wire logic aperture_req,
  output logic aperture_grant
);
  logic page_close_policy;
  logic next_page_close_policy;
  logic freq_sel;
  logic next_freq_sel;
  logic strap_pending;
  logic next_strap_pending;
  logic [2:0] apctl;
  logic [2:0] next_apctl;
  logic lock_written;
  logic next_lock_written;
  logic [7:0] smm_ram;
  logic [7:0] next_smm_ram;
  logic gfx_sel;
  logic dev_visible;
  logic [7:0] rd_value;
  logic [7:0] next_cfg_rdata;
  logic [1:0] gfx_mem;

  mpac_ctl_if ctl_bus ();

  assign gfx_sel = apctl[mpac_pkg::SELECT_BIT];
  assign gfx_mem = smm_ram[mpac_pkg::GFX_MEM_MSB:mpac_pkg::GFX_MEM_LSB];

  // lock and select updates follow the write-once rules
  always_comb begin
    next_page_close_policy = page_close_policy;
    next_freq_sel = freq_sel;
    next_strap_pending = 1'h0;
    next_apctl = apctl;
    next_lock_written = lock_written;
    next_smm_ram = smm_ram;
    if (strap_pending) begin
      next_freq_sel = sysmem_freq_strap;
    end
    // hidden agp registers drop writes as well as reading zero
    if (cfg_write && cfg_dev == mpac_pkg::DEV_HOST
        && !(gfx_sel && cfg_agp_reg)) begin
      if (cfg_offset == mpac_pkg::MEM_CFG_OFFSET) begin
        next_page_close_policy = cfg_wdata[mpac_pkg::POLICY_BIT];
        next_freq_sel = cfg_wdata[mpac_pkg::FREQ_BIT];
      end
      if (cfg_offset == mpac_pkg::APCTL_OFFSET) begin
        next_apctl[mpac_pkg::GATE_BIT] = cfg_wdata[mpac_pkg::GATE_BIT];
        if (!lock_written) begin
          next_apctl[mpac_pkg::LOCK_BIT] = cfg_wdata[mpac_pkg::LOCK_BIT];
          next_lock_written = 1'h1;
        end
        if (!apctl[mpac_pkg::LOCK_BIT]) begin
          next_apctl[mpac_pkg::SELECT_BIT] = cfg_wdata[mpac_pkg::SELECT_BIT];
        end
      end
      if (cfg_offset == mpac_pkg::SMM_RAM_OFFSET) begin
        next_smm_ram = cfg_wdata;
      end
    end
  end

  // strap taken on the first clock after reset release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_close_policy <= 1'h0;
      freq_sel <= 1'h0;
      strap_pending <= 1'h1;
      apctl <= mpac_pkg::APCTL_RESET[2:0];
      lock_written <= 1'h0;
      smm_ram <= mpac_pkg::SMM_RAM_RESET;
    end else begin
      page_close_policy <= next_page_close_policy;
      freq_sel <= next_freq_sel;
      strap_pending <= next_strap_pending;
      apctl <= next_apctl;
      lock_written <= next_lock_written;
      smm_ram <= next_smm_ram;
    end
  end

  // visibility of devices by graphics path select
  always_comb begin
    case (cfg_dev)
      mpac_pkg::DEV_HOST: dev_visible = 1'h1;
      mpac_pkg::DEV_AGP: dev_visible = !gfx_sel;
      mpac_pkg::DEV_GFX: dev_visible = gfx_sel
        && gfx_mem != mpac_pkg::GFX_MEM_OFF;
      default: dev_visible = 1'h0;
    endcase
  end

  always_comb begin
    rd_value = mpac_pkg::ALL_ZEROS;
    if (cfg_dev == mpac_pkg::DEV_HOST) begin
      if (gfx_sel && cfg_agp_reg) begin
        rd_value = mpac_pkg::ALL_ZEROS;
      end else begin
        case (cfg_offset)
          mpac_pkg::MEM_CFG_OFFSET: rd_value = mpac_pkg::MEM_CFG_MASK
            & {4'h0, page_close_policy, freq_sel, 2'h0};
          mpac_pkg::APCTL_OFFSET: rd_value = {5'h00, apctl};
          mpac_pkg::SMM_RAM_OFFSET: rd_value = smm_ram;
          default: rd_value = mpac_pkg::ALL_ZEROS;
        endcase
      end
    end else if (cfg_dev == mpac_pkg::DEV_AGP && gfx_sel) begin
      rd_value = mpac_pkg::ALL_ONES;
    end else if (cfg_dev == mpac_pkg::DEV_GFX && !gfx_sel) begin
      rd_value = mpac_pkg::ALL_ONES;
    end
  end

  // read data holds between reads
  always_comb begin
    next_cfg_rdata = cfg_rdata;
    if (cfg_read) begin
      next_cfg_rdata = rd_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_rdata <= mpac_pkg::ALL_ZEROS;
    end else begin
      cfg_rdata <= next_cfg_rdata;
    end
  end

  assign cfg_claim = (cfg_read || cfg_write) && dev_visible;
  assign aperture_grant = aperture_req
    && apctl[mpac_pkg::GATE_BIT];
  assign agp_enable = !gfx_sel;
  assign gfx_enable = gfx_sel;
  assign sysmem_freq_select = freq_sel;

  assign ctl_bus.page_close_policy = page_close_policy;
  assign ctl_bus.page_miss = page_miss;
  assign ctl_bus.row_change = row_change;
  assign ctl_bus.pages_open = pages_open;
  assign ctl_bus.refresh_start = refresh_start;
  assign precharge = ctl_bus.precharge;

  mpac_precharge u_pre (
    .ref_clk(ref_clk),
    .rst(rst),
    .ctl(ctl_bus)
  );

  sequence s_first_lock_write;
    cfg_write && cfg_dev == mpac_pkg::DEV_HOST
      && cfg_offset == mpac_pkg::APCTL_OFFSET && !lock_written
      && !(gfx_sel && cfg_agp_reg);
  endsequence

  property p_strap_load;
    @(posedge ref_clk) $fell(rst) |-> ##1 freq_sel == $past(sysmem_freq_strap);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("frequency select did not take the strap");

  property p_lock_once;
    @(posedge ref_clk) disable iff (rst)
    lock_written
      |=> apctl[mpac_pkg::LOCK_BIT] == $past(apctl[mpac_pkg::LOCK_BIT]);
  endproperty
  a_lock_once: assert property (p_lock_once)
    else $error("lock bit changed after its first write");

  property p_lock_first;
    @(posedge ref_clk) disable iff (rst)
    s_first_lock_write
      |=> apctl[mpac_pkg::LOCK_BIT] == $past(cfg_wdata[mpac_pkg::LOCK_BIT])
      && lock_written;
  endproperty
  a_lock_first: assert property (p_lock_first)
    else $error("first lock write was not taken");

  property p_select_locked;
    @(posedge ref_clk) disable iff (rst)
    apctl[mpac_pkg::LOCK_BIT] |=> $stable(apctl[mpac_pkg::SELECT_BIT]);
  endproperty
  a_select_locked: assert property (p_select_locked)
    else $error("select changed while locked");

  property p_gate;
    @(posedge ref_clk) disable iff (rst)
    !apctl[mpac_pkg::GATE_BIT] |-> !aperture_grant;
  endproperty
  a_gate: assert property (p_gate)
    else $error("aperture access granted with gate clear");

  property p_dev2_ones;
    @(posedge ref_clk) disable iff (rst)
    (cfg_read && cfg_dev == mpac_pkg::DEV_GFX && !gfx_sel)
      |=> cfg_rdata == mpac_pkg::ALL_ONES;
  endproperty
  a_dev2_ones: assert property (p_dev2_ones)
    else $error("device 2 read in AGP mode not all ones");

  property p_dev1_ones;
    @(posedge ref_clk) disable iff (rst)
    (cfg_read && cfg_dev == mpac_pkg::DEV_AGP && gfx_sel)
      |=> cfg_rdata == mpac_pkg::ALL_ONES && !$past(cfg_claim);
  endproperty
  a_dev1_ones: assert property (p_dev1_ones)
    else $error("device 1 read in graphics mode not all ones");

  property p_gfx_claim;
    @(posedge ref_clk) disable iff (rst)
    (cfg_dev == mpac_pkg::DEV_GFX && cfg_claim)
      |-> gfx_sel && gfx_mem != mpac_pkg::GFX_MEM_OFF;
  endproperty
  a_gfx_claim: assert property (p_gfx_claim)
    else $error("internal graphics claimed a cycle it must ignore");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
    (cfg_read && cfg_dev == mpac_pkg::DEV_HOST
      && cfg_offset == mpac_pkg::APCTL_OFFSET) |=> cfg_rdata[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved aperture control bits read nonzero");
endmodule // mpac_regs

// ### tb/mpac_regs_tb.sv
module mpac_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, sysmem_freq_strap;
  logic [1:0] cfg_dev, precharge;
  logic [7:0] cfg_offset, cfg_wdata, cfg_rdata, rd;
  logic cfg_agp_reg, cfg_read, cfg_write, cfg_claim, clm;
  logic page_miss, row_change, pages_open, refresh_start;
  logic sysmem_freq_select, agp_enable, gfx_enable;
  logic aperture_req, aperture_grant;
  int fail_count, n_tests;

  mpac_regs i_dut (
    .ref_clk(ref_clk), .rst(rst), .sysmem_freq_strap(sysmem_freq_strap),
    .cfg_dev(cfg_dev), .cfg_offset(cfg_offset), .cfg_agp_reg(cfg_agp_reg),
    .cfg_read(cfg_read), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_claim(cfg_claim), .page_miss(page_miss),
    .row_change(row_change), .pages_open(pages_open),
    .refresh_start(refresh_start), .precharge(precharge),
    .sysmem_freq_select(sysmem_freq_select), .agp_enable(agp_enable),
    .gfx_enable(gfx_enable), .aperture_req(aperture_req),
    .aperture_grant(aperture_grant)
  );

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(negedge ref_clk);
    rst = 1'h1;
    sysmem_freq_strap = strap;
    repeat (6) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [1:0] dev, input logic [7:0] off,
                    input logic [7:0] d);
    @(negedge ref_clk);
    cfg_dev = dev;
    cfg_offset = off;
    cfg_agp_reg = 1'h0;
    cfg_wdata = d;
    cfg_write = 1'h1;
    @(negedge ref_clk);
    cfg_write = 1'h0;
  endtask

  // claim is combinational, so it is caught while the strobe is up
  task automatic rdc(input logic [1:0] dev, input logic [7:0] off,
                     input logic agp);
    @(negedge ref_clk);
    cfg_dev = dev;
    cfg_offset = off;
    cfg_agp_reg = agp;
    cfg_read = 1'h1;
    #1 clm = cfg_claim;
    @(negedge ref_clk);
    cfg_read = 1'h0;
    rd = cfg_rdata;
  endtask

  task automatic ev(input logic [3:0] e, input logic [1:0] exp);
    @(negedge ref_clk);
    {page_miss, row_change, pages_open, refresh_start} = e;
    @(negedge ref_clk);
    chk({6'h00, precharge}, {6'h00, exp});
    {page_miss, row_change, pages_open, refresh_start} = 4'h0;
  endtask

  task automatic t_strap();
    do_reset(1'h0);
    chk({7'h00, sysmem_freq_select}, 8'h00);
    do_reset(1'h1);
    chk({7'h00, sysmem_freq_select}, 8'h01);
    rdc(2'h0, 8'h50, 1'h0);
    chk(rd, 8'h04);
    rdc(2'h0, 8'h51, 1'h0);
    chk(rd, 8'h00);
    chk({6'h00, agp_enable, gfx_enable}, 8'h02);
  endtask

  task automatic t_policy();
    wr(2'h0, 8'h50, 8'hFF);
    rdc(2'h0, 8'h50, 1'h0);
    chk(rd, 8'h0C);
    ev(4'h8, mpac_pkg::PRE_ALL);
    ev(4'h1, mpac_pkg::PRE_ALL);
    wr(2'h0, 8'h50, 8'h00);
    chk({7'h00, sysmem_freq_select}, 8'h00);
    ev(4'h8, mpac_pkg::PRE_BANK);
    ev(4'h6, mpac_pkg::PRE_ALL);
    ev(4'h9, mpac_pkg::PRE_ALL);
    ev(4'hC, mpac_pkg::PRE_BANK);
    ev(4'h0, mpac_pkg::PRE_NONE);
  endtask

  // first write leaves the lock clear, so the select stays writable
  task automatic t_lock_open();
    aperture_req = 1'h1;
    #1 chk({7'h00, aperture_grant}, 8'h00);
    wr(2'h0, 8'h51, 8'h03);
    rdc(2'h0, 8'h51, 1'h0);
    chk(rd, 8'h03);
    chk({7'h00, aperture_grant}, 8'h01);
    chk({6'h00, agp_enable, gfx_enable}, 8'h01);
    wr(2'h0, 8'h51, 8'h04);
    rdc(2'h0, 8'h51, 1'h0);
    chk(rd, 8'h00);
    chk({7'h00, aperture_grant}, 8'h00);
    aperture_req = 1'h0;
  endtask

  task automatic t_lock_set();
    do_reset(1'h1);
    wr(2'h0, 8'h51, 8'hFF);
    rdc(2'h0, 8'h51, 1'h0);
    chk(rd, 8'h07);
    wr(2'h0, 8'h51, 8'h00);
    rdc(2'h0, 8'h51, 1'h0);
    chk(rd, 8'h05);
    do_reset(1'h1);
    rdc(2'h0, 8'h51, 1'h0);
    chk(rd, 8'h00);
  endtask

  task automatic t_visible();
    rdc(2'h2, 8'h00, 1'h0);
    chk({clm, rd[6:0]}, 8'h7F);
    rdc(2'h0, 8'h51, 1'h0);
    chk({7'h00, clm}, 8'h01);
    wr(2'h0, 8'h51, 8'h01);
    rdc(2'h1, 8'h00, 1'h0);
    chk({clm, rd[6:0]}, 8'h7F);
    rdc(2'h0, 8'h50, 1'h1);
    chk(rd, 8'h00);
    rdc(2'h2, 8'h00, 1'h0);
    chk({7'h00, clm}, 8'h00);
    wr(2'h0, 8'h70, 8'h40);
    rdc(2'h2, 8'h00, 1'h0);
    chk({7'h00, clm}, 8'h01);
    // a write flagged as agp in graphics mode must leave 50h alone
    @(negedge ref_clk);
    {cfg_dev, cfg_offset, cfg_wdata} = {2'h0, 8'h50, 8'hFF};
    {cfg_agp_reg, cfg_write} = 2'h3;
    @(negedge ref_clk);
    cfg_write = 1'h0;
    rdc(2'h0, 8'h50, 1'h0);
    chk(rd, 8'h04);
    wr(2'h0, 8'h51, 8'h00);
    rdc(2'h2, 8'h00, 1'h0);
    chk({clm, rd[6:0]}, 8'h7F);
  endtask

  initial begin
    {rst, sysmem_freq_strap, cfg_dev, cfg_offset, cfg_wdata} = 20'h80000;
    {cfg_agp_reg, cfg_read, cfg_write, aperture_req} = 4'h0;
    {page_miss, row_change, pages_open, refresh_start} = 4'h0;
    fail_count = 0;
    n_tests = 0;
    t_strap();
    t_policy();
    t_lock_open();
    t_lock_set();
    t_visible();
    finish_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule // mpac_regs_tb
